/* vfc_pkg.sv */
// Purpose: constants and types for the vf display refresh controller
// Assumes: 125 MHz system clock, 32 glyphs of 5x7 dots, two serial drivers
// Notes:   every timing count is derived here from its printed figure

`default_nettype none

package vfc_pkg;

  localparam int CLK_HZ        = 125_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int FRAME_MS      = 10;
  localparam int DIGITS        = 32;
  // longest time: rounds down
  localparam int DIGIT_CYC     = CLK_HZ / 1000 * FRAME_MS / DIGITS;
  // one clock phase; 625 ns keeps both drivers under their clock limits
  localparam int PHASE_NS      = 625;
  localparam int PH_CYC        = (PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int BIT_CYC       = 3 * PH_CYC;
  localparam int BLANK_MIN_US  = 20;
  localparam int BLANK_MIN_CYC = BLANK_MIN_US * CLK_MHZ;
  localparam int ROWS          = 7;
  localparam int COLS          = 5;
  localparam int SEG_BITS      = ROWS * COLS;
  localparam int STREAM_BITS   = SEG_BITS + 1;
  localparam logic START_BIT   = 1'h1;
  localparam int FIFO_DEPTH    = 8;
  localparam int EXT_W         = 12;

  typedef logic [COLS-1:0] vfc_row_t;

  // row[0] is the bottom row of the glyph
  typedef struct packed {
    vfc_row_t [ROWS-1:0] row;
  } vfc_glyph_t;

  typedef struct packed {
    logic seg_data;
    logic seg_clk;
    logic dig_data;
    logic dig_clk;
    logic blank;
  } vfc_pins_t;

endpackage : vfc_pkg

`default_nettype wire

/* vfc_refresh.sv */
// Purpose: refresh sequencer for a 32 glyph vf display with brightness
// Assumes: user logic shares clk_sys; driver pins are outputs only
// Notes:   glyphs enter through an 8 word fifo and a staging buffer

`default_nettype none

module vfc_fifo #(
  parameter int W = 35,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic         in_ready,
  // drain side
  output var  logic         out_valid,
  output var  logic [W-1:0] out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(D);

  if (D < 2 || (D & (D - 1)) != 0)
  begin : g_bad_depth
    $error("vfc_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem[rd_reg];

  always_comb
  begin
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wr_reg] <= in_data;
  end

  // ready is registered so the fill side sees a flop, not a path
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg   <= '0;
      rd_reg   <= '0;
      cnt_reg  <= '0;
      in_ready <= 1'b1;
    end
    else if (ce)
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      cnt_reg  <= cnt_next;
      in_ready <= cnt_next != (AW+1)'(D);
    end
  end

endmodule : vfc_fifo

module vfc_refresh #(
  parameter int DIGIT_CYC = vfc_pkg::DIGIT_CYC,
  parameter int EXT_W     = vfc_pkg::EXT_W,
  // driver clock phase and minimum inter-digit blank, in clk_sys cycles
  parameter int PH_CYC    = vfc_pkg::PH_CYC,
  parameter int BLANK_CYC = vfc_pkg::BLANK_MIN_CYC
) (
  // clock, reset, clock enable
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic               clk_en,
  // control
  input  wire logic               run,
  input  wire logic [EXT_W-1:0]   blank_ext,
  // glyph stream in
  input  wire logic               glyph_valid,
  input  wire vfc_pkg::vfc_glyph_t glyph_data,
  output var  logic               glyph_ready,
  // driver pins
  output var  vfc_pkg::vfc_pins_t drv,
  // status
  output var  logic               refreshing,
  output var  logic               frame_done
);

  localparam int BIT_CYC = 3 * PH_CYC;
  localparam int PW  = $clog2(DIGIT_CYC);
  localparam int HW  = $clog2(BLANK_CYC + (1 << EXT_W));
  localparam int PHW = $clog2(BIT_CYC);
  localparam int FIXED = (vfc_pkg::STREAM_BITS + 2) * BIT_CYC;

  // a blank waveform slower than 100 Hz would be seen to flicker
  if (EXT_W < 1 || EXT_W > 16 || PH_CYC < 1 || BLANK_CYC < 1 ||
      DIGIT_CYC >= vfc_pkg::CLK_HZ / 100 ||
      DIGIT_CYC <= FIXED + BLANK_CYC + (1 << EXT_W))
  begin : g_bad_period
    $error("vfc_refresh digit period too short for the blank extension");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_CLEAR, ST_SHIFT, ST_DIG,
    ST_LAST, ST_HOLD, ST_ON, ST_HALT
  } vfc_state_t;

  // start bit first, then rows top to bottom, each row lsb first
  function automatic logic seg_bit(
    input vfc_pkg::vfc_glyph_t g,
    input logic [5:0]          idx
  );
    int j;
    j = int'(idx) - 1;
    if (idx == 6'h00)
      return vfc_pkg::START_BIT;
    return g.row[vfc_pkg::ROWS - 1 - j / vfc_pkg::COLS]
                [j % vfc_pkg::COLS];
  endfunction : seg_bit

  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  vfc_state_t          state_reg;
  logic [4:0]          digit_reg;
  logic [5:0]          bit_reg;
  logic [PHW-1:0]      ph_reg;
  logic [PW-1:0]       per_reg;
  logic [HW-1:0]       hold_reg;
  logic [5:0]          stage_cnt_reg;
  logic                disp_ok_reg;
  logic [vfc_pkg::SEG_BITS-1:0] stage_mem [vfc_pkg::DIGITS];
  logic [vfc_pkg::SEG_BITS-1:0] disp_mem  [vfc_pkg::DIGITS];
  logic                fifo_valid;
  logic [vfc_pkg::SEG_BITS-1:0] fifo_q;
  logic                stage_full;
  logic                pop;
  logic                bit_end;
  logic                per_end;
  logic                frame_end;
  logic                commit;
  vfc_pkg::vfc_glyph_t cur_glyph;

  vfc_fifo #(
    .W (vfc_pkg::SEG_BITS),
    .D (vfc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .ce        (clk_en),
    .in_valid  (glyph_valid),
    .in_data   (glyph_data),
    .in_ready  (glyph_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_q),
    .out_ready (!stage_full)
  );

  assign stage_full = stage_cnt_reg == 6'(vfc_pkg::DIGITS);
  assign pop        = fifo_valid && !stage_full;
  assign bit_end    = ph_reg == PHW'(BIT_CYC - 1);
  assign per_end    = state_reg == ST_ON && per_reg == PW'(DIGIT_CYC - 1);
  assign frame_end  = per_end && digit_reg == 5'(vfc_pkg::DIGITS - 1);
  // a full stage set swaps in only at a frame boundary
  assign commit     = frame_end && stage_full;
  assign cur_glyph  = disp_ok_reg ? disp_mem[digit_reg] : '0;

  // staging buffer: the fifo stalls once 32 glyphs wait for a frame end
  always_ff @(posedge clk_sys)
  begin
    if (clk_en && pop)
      stage_mem[stage_cnt_reg[4:0]] <= fifo_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (clk_en && commit)
      disp_mem <= stage_mem;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_cnt_reg <= 6'h00;
      disp_ok_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (commit)
      begin
        stage_cnt_reg <= 6'h00;
        disp_ok_reg   <= 1'b1;
      end
      else if (pop)
        stage_cnt_reg <= stage_cnt_reg + 6'h01;
    end
  end

  // sequencer: state, digit, bit, phase and period counters
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      digit_reg <= 5'h00;
      bit_reg   <= 6'h00;
      ph_reg    <= '0;
      per_reg   <= '0;
      hold_reg  <= '0;
    end
    else if (clk_en)
    begin
      ph_reg <= bit_end ? '0 : ph_reg + 1'b1;
      if (state_reg inside {ST_SHIFT, ST_DIG, ST_LAST, ST_HOLD, ST_ON})
        per_reg <= per_end ? '0 : per_reg + 1'b1;
      else
        per_reg <= '0;
      case (state_reg)
        ST_IDLE, ST_HALT:
        begin
          ph_reg  <= '0;
          bit_reg <= 6'h00;
          if (run)
            state_reg <= ST_CLEAR;
        end
        ST_CLEAR:
          if (bit_end)
          begin
            if (bit_reg == 6'(vfc_pkg::STREAM_BITS - 1))
            begin
              bit_reg   <= 6'h00;
              digit_reg <= 5'h00;
              state_reg <= ST_SHIFT;
            end
            else
              bit_reg <= bit_reg + 6'h01;
          end
        ST_SHIFT:
          if (bit_end)
          begin
            if (bit_reg == 6'(vfc_pkg::SEG_BITS - 1))
              state_reg <= ST_DIG;
            bit_reg <= bit_reg + 6'h01;
          end
        ST_DIG:
          if (bit_end)
            state_reg <= ST_LAST;
        ST_LAST:
          if (bit_end)
          begin
            state_reg <= ST_HOLD;
            // extension is added to blank; the period stays fixed
            hold_reg  <= HW'(BLANK_CYC - 1)
                       + HW'(blank_ext);
          end
        ST_HOLD:
          if (hold_reg == '0)
            state_reg <= ST_ON;
          else
            hold_reg <= hold_reg - 1'b1;
        ST_ON:
          if (per_end)
          begin
            ph_reg    <= '0;
            bit_reg   <= 6'h00;
            digit_reg <= digit_reg + 5'h01;
            // scanning never waits for new data
            if (frame_end && !run)
              state_reg <= ST_HALT;
            else
              state_reg <= ST_SHIFT;
          end
          else
            ph_reg <= '0;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // driver pins, all from flops; clocks rise at one phase, fall at two
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drv       <= '0;
      drv.blank <= 1'b1;
    end
    else if (clk_en)
    begin
      if (ph_reg == PHW'(2 * PH_CYC))
      begin
        drv.seg_clk <= 1'b0;
        drv.dig_clk <= 1'b0;
      end
      case (state_reg)
        ST_IDLE, ST_HALT:
        begin
          drv       <= '0;
          drv.blank <= 1'b1;
        end
        ST_CLEAR:
        begin
          drv.seg_data <= 1'b0;
          drv.dig_data <= 1'b0;
          if (ph_reg == PHW'(PH_CYC))
          begin
            drv.seg_clk <= 1'b1;
            drv.dig_clk <= bit_reg < 6'(vfc_pkg::DIGITS);
          end
          if (bit_end && bit_reg == 6'(vfc_pkg::STREAM_BITS - 1))
            drv.blank <= 1'b0;
        end
        ST_SHIFT, ST_LAST:
        begin
          if (ph_reg == '0)
            drv.seg_data <= seg_bit(cur_glyph, bit_reg);
          if (ph_reg == PHW'(PH_CYC))
            drv.seg_clk <= 1'b1;
          if (state_reg == ST_SHIFT && bit_end &&
              bit_reg == 6'(vfc_pkg::SEG_BITS - 1))
            drv.blank <= 1'b1;
        end
        ST_DIG:
        begin
          if (ph_reg == '0)
            drv.dig_data <= digit_reg == 5'h00;
          if (ph_reg == PHW'(PH_CYC))
            drv.dig_clk <= 1'b1;
        end
        ST_HOLD:
          if (hold_reg == '0)
            drv.blank <= 1'b0;
        ST_ON:
          if (frame_end && !run)
            drv.blank <= 1'b1;
        default:
          drv.blank <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refreshing <= 1'b0;
      frame_done <= 1'b0;
    end
    else if (clk_en)
    begin
      refreshing <= !(state_reg inside {ST_IDLE, ST_HALT});
      frame_done <= frame_end;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n || !clk_en);

  shift_blank_low_a: assert property (
    state_reg == ST_SHIFT && ph_reg == PHW'(1) |-> !drv.blank)
    else $error("blank high while segment bits shift");

  latch_blanked_a: assert property (
    state_reg inside {ST_DIG, ST_LAST} && ph_reg != '0 |-> drv.blank)
    else $error("digit advance or latch not blanked");

  period_wrap_a: assert property (
    per_end |=> per_reg == '0 &&
    state_reg inside {ST_SHIFT, ST_HALT})
    else $error("digit period did not wrap");

  seg_data_hold_a: assert property (
    $changed(drv.seg_data) |-> !drv.seg_clk && !$past(drv.seg_clk))
    else $error("segment data changed around a clock pulse");

  start_bit_a: assert property (
    state_reg == ST_SHIFT && bit_reg == 6'h00 &&
    ph_reg == PHW'(PH_CYC) |-> drv.seg_data)
    else $error("start bit not one");

  digit_one_a: assert property (
    $rose(drv.dig_clk) && state_reg == ST_DIG |->
    drv.dig_data == (digit_reg == 5'h00))
    else $error("digit driver fed wrong bit");

  stage_held_a: assert property (
    stage_full && !frame_end |=> stage_full)
    else $error("staged glyphs swapped outside frame end");

  halt_blank_a: assert property (
    state_reg == ST_HALT |-> drv.blank && !drv.seg_clk && !drv.dig_clk)
    else $error("blank not held while refresh is halted");

  hold_load_a: assert property (
    state_reg == ST_LAST && bit_end |=>
    hold_reg == HW'(BLANK_CYC - 1) + HW'($past(blank_ext)))
    else $error("blank extension not loaded");

  release_a: assert property (
    state_reg == ST_HOLD && hold_reg == '0 |=> !drv.blank ##1 !drv.blank)
    else $error("blank not released after hold");

endmodule : vfc_refresh

`default_nettype wire

/* vfc_drv_model.sv */
// Purpose: behavioural segment and digit drivers facing the controller
// Assumes: pins come straight from the controller, no wire delay
// Notes:   registers power up as all ones, so only a real clear empties

`default_nettype none

module vfc_drv_model (
  // power-up
  input  wire logic               reset_n,
  // driver pins
  input  wire vfc_pkg::vfc_pins_t drv,
  // internal state seen by the bench
  output var  logic [34:0]        seg_lat,
  output var  logic [35:0]        sreg,
  output var  logic [31:0]        dig_sr
);
  timeunit 1ns;
  timeprecision 1ps;

  // the start bit reaching the far end latches the outputs
  always_ff @(posedge drv.seg_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sreg    <= '1;
      seg_lat <= '1;
    end
    else if (sreg[34])
    begin
      seg_lat <= {sreg[33:0], drv.seg_data};
      sreg    <= '0;
    end
    else
      sreg <= {sreg[34:0], drv.seg_data};
  end

  // one-hot walks one place per digit clock
  always_ff @(posedge drv.dig_clk or negedge reset_n)
  begin
    if (!reset_n)
      dig_sr <= '1;
    else
      dig_sr <= {dig_sr[30:0], drv.dig_data};
  end
  // blank high would hide seg_lat on the glass
endmodule : vfc_drv_model

`default_nettype wire

/* vfc_refresh_tb.sv */
// Purpose: self-checking bench for the vf refresh controller
// Assumes: shortened digit period so whole frames fit in the run
// Notes:   pins are sampled on the falling clock edge

`default_nettype none

module vfc_refresh_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // short phase and blank keep a whole frame inside the run
  localparam int PH = 2;
  localparam int BL = 20;
  localparam int DC = 300;
  localparam int EW = 4;

  logic                clk_sys;
  logic                reset_n;
  logic                clk_en;
  logic                run;
  logic [EW-1:0]       blank_ext;
  logic                glyph_valid;
  vfc_pkg::vfc_glyph_t glyph_data;
  logic                glyph_ready;
  vfc_pkg::vfc_pins_t  drv;
  logic                refreshing;
  logic                frame_done;
  logic [34:0]         seg_lat;
  logic [35:0]         sreg;
  logic [31:0]         dig_sr;
  int                  fails;
  int                  checked;
  int                  cyc = 0;
  int                  rise_prev;

  vfc_refresh #(
    .DIGIT_CYC (DC),
    .EXT_W     (EW),
    .PH_CYC    (PH),
    .BLANK_CYC (BL)
  ) i_dut (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .run         (run),
    .blank_ext   (blank_ext),
    .glyph_valid (glyph_valid),
    .glyph_data  (glyph_data),
    .glyph_ready (glyph_ready),
    .drv         (drv),
    .refreshing  (refreshing),
    .frame_done  (frame_done)
  );

  vfc_drv_model i_drv (
    .reset_n (reset_n),
    .drv     (drv),
    .seg_lat (seg_lat),
    .sreg    (sreg),
    .dig_sr  (dig_sr)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic chk(input string w, input logic [63:0] e,
                     input logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", w, e, g);
    end
  endtask : chk

  function automatic vfc_pkg::vfc_glyph_t mk(input int n);
    vfc_pkg::vfc_glyph_t g;
    for (int r = 0; r < vfc_pkg::ROWS; r++)
      g.row[r] = 5'((n * 7 + r * 11 + 3) % 32);
    return g;
  endfunction : mk

  // top row first, each row lsb first, first bit ends deepest
  function automatic logic [34:0] pat(input vfc_pkg::vfc_glyph_t g);
    logic [34:0] p;
    for (int r = 6; r >= 0; r--)
      for (int b = 0; b < 5; b++)
        p[34 - (6 - r) * 5 - b] = g.row[r][b];
    return p;
  endfunction : pat

  task automatic t_reset();
    @(negedge clk_sys);
    chk("idle pins", 5'h01, drv);
    chk("ready", 1'b1, glyph_ready);
    chk("refreshing", 1'b0, refreshing);
    repeat (4) @(posedge clk_sys);
  endtask : t_reset

  // fifo plus a full staging set must refuse the 41st glyph
  task automatic t_fill();
    int n;
    n = 0;
    glyph_valid <= 1'b1;
    glyph_data  <= mk(0);
    repeat (60)
    begin
      @(posedge clk_sys);
      if (glyph_ready === 1'b1)
      begin
        n++;
        glyph_data <= mk(n);
      end
    end
    glyph_valid <= 1'b0;
    chk("glyphs taken", 40, n);
  endtask : t_fill

  task automatic t_clear();
    int s, d, bad, i;
    vfc_pkg::vfc_pins_t p, q;
    s = 0;
    d = 0;
    bad = 0;
    p = drv;
    for (i = 0; i < 20000; i++)
    begin
      if (i == 40)
      begin
        @(posedge clk_sys);
        clk_en <= 1'b0;
        // snapshot apart from p so an edge just before the freeze counts
        @(negedge clk_sys);
        q = drv;
        repeat (200) @(negedge clk_sys);
        chk("frozen pins", q, drv);
        @(posedge clk_sys);
        clk_en <= 1'b1;
      end
      @(negedge clk_sys);
      q = drv;
      s += int'(q.seg_clk && !p.seg_clk);
      d += int'(q.dig_clk && !p.dig_clk);
      bad += int'(q.seg_data || q.dig_data);
      if (!q.blank && p.blank)
        break;
      p = q;
    end
    chk("clear seg clocks", 36, s);
    chk("clear dig clocks", 32, d);
    chk("clear data ones", 0, bad);
    chk("seg shift empty", 36'h0_0000_0000, sreg);
    chk("digit empty", 32'h0000_0000, dig_sr);
    chk("refreshing", 1'b1, refreshing);
    rise_prev = -1;
  endtask : t_clear

  task automatic t_digit(input int k, input logic [EW-1:0] ext,
                         input logic cp);
    int s, d, ds, hi, i;
    vfc_pkg::vfc_pins_t p, q;
    @(posedge clk_sys);
    blank_ext <= ext;
    @(negedge clk_sys);
    p = drv;
    s = 0;
    d = 0;
    ds = 0;
    hi = 0;
    for (i = 0; i < 3 * DC; i++)
    begin
      @(negedge clk_sys);
      q = drv;
      s += int'(q.seg_clk && !p.seg_clk);
      if (q.dig_clk && !p.dig_clk)
      begin
        d++;
        ds = int'(q.dig_data);
      end
      hi += int'(q.blank);
      if (q.blank && !p.blank)
      begin
        chk("shift bits", 35, s);
        chk("digit early", 0, d);
        if (rise_prev >= 0)
          chk("period", DC, cyc - rise_prev);
        rise_prev = cyc;
      end
      if (!q.blank && p.blank)
        break;
      p = q;
    end
    chk("seg bits", 36, s);
    chk("digit clocks", 1, d);
    chk("digit data", k == 0, ds);
    chk("digit select", 32'h0000_0001 << k, dig_sr);
    // digit bit, latch bit, then the minimum blank plus the extension
    chk("hold less ext", 6 * PH + BL, hi - int'(ext));
    if (cp)
      chk("segments", pat(mk(k)), seg_lat);
  endtask : t_digit

  task automatic t_frame();
    int i, n;
    for (i = 0; i < 32; i++)
    begin
      t_digit(i, EW'(i % 16), 1'b0);
      if (i == 16)
      begin
        @(posedge clk_sys);
        run <= 1'b0;
      end
    end
    n = 0;
    for (i = 0; i < DC; i++)
    begin
      @(negedge clk_sys);
      if (frame_done === 1'b1)
        n++;
      else if (n > 0)
        break;
    end
    chk("frame pulse", 1, n);
  endtask : t_frame

  task automatic t_halt();
    int i, bad;
    bad = 0;
    repeat (8) @(negedge clk_sys);
    chk("halted", 1'b0, refreshing);
    chk("ready freed", 1'b1, glyph_ready);
    for (i = 0; i < 3000; i++)
    begin
      @(negedge clk_sys);
      bad += int'(drv.blank !== 1'b1 || drv.seg_clk !== 1'b0);
    end
    chk("dark pins", 0, bad);
    @(posedge clk_sys);
  endtask : t_halt

  task automatic print_verdict();
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end

  initial
  begin
    fails = 0;
    checked = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    run = 1'b0;
    blank_ext = '0;
    glyph_valid = 1'b0;
    glyph_data = '0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_fill();
    run <= 1'b1;
    t_clear();
    t_frame();
    t_halt();
    run <= 1'b1;
    t_clear();
    for (int k = 0; k < 4; k++)
      t_digit(k, EW'(k * 5), 1'b1);
    print_verdict();
  end
endmodule : vfc_refresh_tb

`default_nettype wire
